// >>> lot_flash_lockdown_otp.sv
// serial command logic for lockdown query, security area program and read
`timescale 1ns/1ps
module lot_flash_lockdown_otp #(
  parameter int NUM_SECTORS = 32,
  parameter int PROG_CYCLES = lot_pkg::PROG_CYCLES_DFLT
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic [NUM_SECTORS-1:0] lockdown_i,
  input wire logic write_enable_latch_i,
  input wire logic [5:0] status_hi_i,
  input wire logic suspend_req_i,
  output logic ready_busy_flag_o,
  output logic wel_clear_o,
  output logic suspend_rej_o
);
  localparam int SW = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;
  localparam int PCW = $clog2(PROG_CYCLES + 1);

  // user bytes kept inverted so an all-zero reset reads as erased FFh
  typedef struct packed {
    lot_pkg::lot_state_t st;
    logic sck_q;
    logic cs_q;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] op;
    logic [7:0] sh;
    logic [23:0] addr;
    logic [7:0] tx;
    logic so;
    logic oe;
    logic pcmd;
    logic seen;
    logic done;
    logic busy;
    logic [PCW-1:0] cnt;
    logic wel_clr;
    logic sus_rej;
    logic [5:0] ptr;
    logic [63:0][7:0] pbuf;
    logic [63:0] mask;
    logic [63:0][7:0] otp_n;
  } lot_regs_t;

  lot_regs_t s_r;
  lot_regs_t s_nxt;
  logic rise;
  logic fall;
  logic [7:0] inb;
  logic [7:0] stat;
  logic locked;
  logic [23:0] addr_full;

  ////////////////////////////////////////////////////////////////////////////
  // read path: low half from the user array, upper half fixed per part
  function automatic logic [7:0] otp_byte(input logic [6:0] a, input logic [63:0][7:0] mem_n);
    if (a[6]) begin
      otp_byte = lot_pkg::FACTORY_SEED ^ {2'b00, a[5:0]};
    end else begin
      otp_byte = ~mem_n[a[5:0]];
    end
  endfunction

  // edge detect on the sampled serial clock, mode 0 and 3 alike
  assign rise = !s_r.sck_q && sck_i;
  assign fall = s_r.sck_q && !sck_i;
  assign inb = {s_r.sh[6:0], si_i};
  assign stat = {status_hi_i, write_enable_latch_i, s_r.busy};
  assign locked = lockdown_i[s_r.addr[lot_pkg::SECT_LSB +: SW]];
  // whole address as the third address byte completes, sector bits need all 24
  assign addr_full = {s_r.addr[15:0], inb};

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_q = sck_i;
    s_nxt.cs_q = cs_b_i;
    s_nxt.wel_clr = 1'b0;
    s_nxt.sus_rej = suspend_req_i && s_r.busy;
    // self-timed cycle; buffer copied only at the end
    if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0;
        for (int i = 0; i < lot_pkg::USER_BYTES; i++) begin
          if (s_r.mask[i]) begin
            s_nxt.otp_n[i] = ~s_r.pbuf[i];
          end
        end
      end else begin
        s_nxt.cnt = s_r.cnt - PCW'(1);
      end
    end
    if (cs_b_i) begin
      // release ends any command and floats the output
      s_nxt.st = lot_pkg::LOT_OPCODE;
      s_nxt.oe = 1'b0;
      s_nxt.so = 1'b0;
      s_nxt.bit_cnt = '0;
      s_nxt.byte_cnt = '0;
      if (!s_r.cs_q && s_r.pcmd) begin
        s_nxt.pcmd = 1'b0;
        s_nxt.wel_clr = 1'b1;
        // done is set at start so a lost cycle still refuses later tries
        if (s_r.st == lot_pkg::LOT_PROG_DATA && s_r.seen && s_r.bit_cnt == '0 && !s_r.done) begin
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.cnt = PCW'(PROG_CYCLES - 1);
        end
      end
    end else begin
      if (rise) begin
        s_nxt.sh = inb;
        s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
        if (s_r.bit_cnt == lot_pkg::LAST_BIT) begin
          unique case (s_r.st)
            lot_pkg::LOT_OPCODE: begin
              s_nxt.op = inb;
              s_nxt.byte_cnt = '0;
              if (inb == lot_pkg::OP_STAT_RD) begin
                s_nxt.st = lot_pkg::LOT_STAT_OUT;
                s_nxt.tx = stat;
              end else if (s_r.busy) begin
                // only status is served during a program cycle
                s_nxt.st = lot_pkg::LOT_IGNORE;
              end else if (inb == lot_pkg::OP_LOCK_RD || inb == lot_pkg::OP_OTP_RD) begin
                s_nxt.st = lot_pkg::LOT_ADDR;
              end else if (inb == lot_pkg::OP_OTP_PROG && write_enable_latch_i) begin
                s_nxt.st = lot_pkg::LOT_ADDR;
                s_nxt.pcmd = 1'b1;
                s_nxt.mask = '0;
                s_nxt.seen = 1'b0;
              end else begin
                s_nxt.st = lot_pkg::LOT_IGNORE;
              end
            end
            lot_pkg::LOT_ADDR: begin
              s_nxt.addr = {s_r.addr[15:0], inb};
              s_nxt.byte_cnt = s_r.byte_cnt + 3'h1;
              if (s_r.byte_cnt == lot_pkg::ADDR_BYTES - 3'h1) begin
                if (s_r.op == lot_pkg::OP_LOCK_RD) begin
                  s_nxt.st = lot_pkg::LOT_LOCK_OUT;
                  s_nxt.tx = lot_pkg::BYTE_UNLOCKED;
                  if (lockdown_i[addr_full[lot_pkg::SECT_LSB +: SW]]) begin
                    s_nxt.tx = lot_pkg::BYTE_LOCKED;
                  end
                end else if (s_r.op == lot_pkg::OP_OTP_RD) begin
                  s_nxt.st = lot_pkg::LOT_DUMMY;
                end else begin
                  s_nxt.st = lot_pkg::LOT_PROG_DATA;
                  s_nxt.ptr = inb[5:0];
                end
              end
            end
            lot_pkg::LOT_DUMMY: begin
              s_nxt.byte_cnt = s_r.byte_cnt + 3'h1;
              if (s_r.byte_cnt == lot_pkg::HDR_RD_BYTES - 3'h1) begin
                s_nxt.st = lot_pkg::LOT_RD_OUT;
                s_nxt.tx = otp_byte(s_r.addr[6:0], s_r.otp_n);
                s_nxt.addr[6:0] = s_r.addr[6:0] + 7'h01;
              end
            end
            lot_pkg::LOT_PROG_DATA: begin
              // later bytes overwrite earlier ones at the same slot
              s_nxt.pbuf[s_r.ptr] = inb;
              s_nxt.mask[s_r.ptr] = 1'b1;
              s_nxt.ptr = s_r.ptr + 6'h01;
              s_nxt.seen = 1'b1;
            end
            lot_pkg::LOT_LOCK_OUT: begin
              s_nxt.tx = s_r.tx;
            end
            lot_pkg::LOT_RD_OUT: begin
              s_nxt.tx = otp_byte(s_r.addr[6:0], s_r.otp_n);
              s_nxt.addr[6:0] = s_r.addr[6:0] + 7'h01;
            end
            lot_pkg::LOT_STAT_OUT: begin
              s_nxt.tx = stat;
            end
            lot_pkg::LOT_IGNORE: begin
              s_nxt.tx = s_r.tx;
            end
          endcase
        end
      end
      // shift out msb first on the falling edge
      if (fall && (s_r.st == lot_pkg::LOT_LOCK_OUT || s_r.st == lot_pkg::LOT_RD_OUT ||
                   s_r.st == lot_pkg::LOT_STAT_OUT)) begin
        s_nxt.so = s_r.tx[~s_r.bit_cnt];
        s_nxt.oe = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign so_o = s_r.so;
  assign so_oe_o = s_r.oe;
  assign ready_busy_flag_o = s_r.busy;
  assign wel_clear_o = s_r.wel_clr;
  assign suspend_rej_o = s_r.sus_rej;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // helpers shared by the properties below
  logic cs_rise;
  logic prog_ok;
  assign cs_rise = cs_b_i && !s_r.cs_q;
  assign prog_ok = s_r.st == lot_pkg::LOT_PROG_DATA && s_r.seen && s_r.bit_cnt == '0 && !s_r.done;

  // framing, program accept or abort, pointer and wrap
  lock_byte_a: assert property (s_r.st == lot_pkg::LOT_LOCK_OUT |->
      (s_r.tx == lot_pkg::BYTE_LOCKED) == locked) else $error("lockdown byte wrong");
  cs_float_a: assert property (cs_b_i |=> !so_oe_o ##1 !so_oe_o or !cs_b_i)
      else $error("output not floated");
  prog_wrap_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_PROG_DATA &&
      s_r.bit_cnt == lot_pkg::LAST_BIT |=> s_r.ptr == $past(s_r.ptr) + 6'h01)
      else $error("program pointer not modulo 64");
  abort_prog_a: assert property (cs_rise && s_r.pcmd && !prog_ok |=>
      wel_clear_o && $stable(ready_busy_flag_o)) else $error("bad program not aborted");
  start_prog_a: assert property (cs_rise && s_r.pcmd && prog_ok |=>
      ready_busy_flag_o && wel_clear_o ##1 ready_busy_flag_o) else $error("program not started");
  once_only_a: assert property ($rose(ready_busy_flag_o) |-> !$past(s_r.done))
      else $error("second program cycle started");
  suspend_rej_a: assert property (suspend_req_i && ready_busy_flag_o |=> suspend_rej_o)
      else $error("suspend not refused");
  no_latch_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_OPCODE &&
      s_r.bit_cnt == lot_pkg::LAST_BIT && inb == lot_pkg::OP_OTP_PROG && !write_enable_latch_i
      |=> !s_r.pcmd) else $error("program taken without latch");
  rd_wrap_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_RD_OUT &&
      s_r.bit_cnt == lot_pkg::LAST_BIT && s_r.addr[6:0] == 7'h7F |=> s_r.addr[6:0] == 7'h00)
      else $error("read did not wrap");

  // header decode: status load, busy gating, buffer reset, start pointer, phase entry
  stat_load_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_OPCODE &&
      s_r.bit_cnt == lot_pkg::LAST_BIT && inb == lot_pkg::OP_STAT_RD |=>
      s_r.st == lot_pkg::LOT_STAT_OUT && s_r.tx[0] == $past(s_r.busy)) else $error("status byte not loaded");
  busy_gate_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_OPCODE && s_r.busy &&
      s_r.bit_cnt == lot_pkg::LAST_BIT && inb != lot_pkg::OP_STAT_RD |=> s_r.st == lot_pkg::LOT_IGNORE)
      else $error("command served while busy");
  buf_clear_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_OPCODE && !s_r.busy &&
      s_r.bit_cnt == lot_pkg::LAST_BIT && inb == lot_pkg::OP_OTP_PROG && write_enable_latch_i |=>
      s_r.pcmd && s_r.mask == '0) else $error("page buffer not reset");
  start_ptr_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_ADDR &&
      s_r.op == lot_pkg::OP_OTP_PROG && s_r.bit_cnt == lot_pkg::LAST_BIT && s_r.byte_cnt == lot_pkg::ADDR_BYTES - 3'h1
      |=> s_r.st == lot_pkg::LOT_PROG_DATA && s_r.ptr == s_r.sh[5:0]) else $error("start location wrong");
  lock_enter_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_ADDR &&
      s_r.op == lot_pkg::OP_LOCK_RD && s_r.bit_cnt == lot_pkg::LAST_BIT && s_r.byte_cnt == lot_pkg::ADDR_BYTES - 3'h1
      |=> s_r.st == lot_pkg::LOT_LOCK_OUT) else $error("lockdown output not entered");
  rd_load_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_DUMMY &&
      s_r.bit_cnt == lot_pkg::LAST_BIT && s_r.byte_cnt == lot_pkg::HDR_RD_BYTES - 3'h1
      |=> s_r.st == lot_pkg::LOT_RD_OUT) else $error("read data not started after dummies");

  // output path: fixed factory half, steady lockdown byte, status drive
  factory_half_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_RD_OUT && s_r.addr[6] &&
      s_r.bit_cnt == lot_pkg::LAST_BIT |=> s_r.tx == (lot_pkg::FACTORY_SEED ^ {2'h0, $past(s_r.addr[5:0])}))
      else $error("factory byte changed");
  lock_steady_a: assert property (s_r.st == lot_pkg::LOT_LOCK_OUT |=> $stable(s_r.tx))
      else $error("lockdown byte not repeated");
  stat_drive_a: assert property (fall && !cs_b_i && s_r.st == lot_pkg::LOT_STAT_OUT |=> so_oe_o)
      else $error("status bit not driven");

  // program cycle: buffer slots, bounded count, bytes land, once only, latch and suspend
  data_slot_a: assert property (rise && !cs_b_i && s_r.st == lot_pkg::LOT_PROG_DATA &&
      s_r.bit_cnt == lot_pkg::LAST_BIT |=> s_r.mask[$past(s_r.ptr)] && s_r.pbuf[$past(s_r.ptr)] == s_r.sh)
      else $error("data byte not buffered");
  cnt_range_a: assert property (ready_busy_flag_o |-> s_r.cnt <= PCW'(PROG_CYCLES - 1))
      else $error("program counter out of range");
  prog_land_a: assert property (s_r.busy && s_r.cnt == '0 && s_r.mask[0] |=>
      !ready_busy_flag_o && s_r.otp_n[0] == ~$past(s_r.pbuf[0])) else $error("buffered byte not programmed");
  done_hold_a: assert property (s_r.done |=> s_r.done)
      else $error("programmed-once flag lost");
  ignore_keep_a: assert property (cs_rise && !s_r.pcmd |=> !wel_clear_o)
      else $error("latch cleared by ignored command");
  susp_idle_a: assert property (!ready_busy_flag_o |=> !suspend_rej_o)
      else $error("suspend refused while idle");

  // main scenarios reached
  prog_run_c: cover property (cs_rise && s_r.pcmd && prog_ok);
  lock_read_c: cover property (s_r.st == lot_pkg::LOT_LOCK_OUT && so_oe_o);
  otp_read_c: cover property (s_r.st == lot_pkg::LOT_RD_OUT && s_r.addr[6:0] == 7'h00);
  prog_refused_c: cover property (cs_rise && s_r.pcmd && s_r.done);
  lock_set_c: cover property (s_r.st == lot_pkg::LOT_LOCK_OUT && s_r.tx == lot_pkg::BYTE_LOCKED);
endmodule

// >>> lot_pkg.sv
// constants and types for the lockdown query and security area access logic
package lot_pkg;
  localparam logic [7:0] OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_OTP_PROG = 8'h9B;
  localparam logic [7:0] OP_OTP_RD = 8'h77;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] BYTE_UNLOCKED = 8'h00;
  localparam logic [7:0] BYTE_LOCKED = 8'hFF;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] HDR_RD_BYTES = 3'h5;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int USER_BYTES = 64;
  localparam int SECT_LSB = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SECURITY_PROGRAM_TIME_US = 500;
  localparam int PROG_CYCLES_DFLT = SECURITY_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  // arbitrary value, seeds the fixed per-part half of the area
  localparam logic [7:0] FACTORY_SEED = 8'h5A;

  typedef enum logic [2:0] {
    LOT_OPCODE,
    LOT_ADDR,
    LOT_DUMMY,
    LOT_PROG_DATA,
    LOT_LOCK_OUT,
    LOT_RD_OUT,
    LOT_STAT_OUT,
    LOT_IGNORE
  } lot_state_t;
endpackage

// >>> lot_host.sv
// host side serial controller model, mode 0, for the lockdown and security area commands
`timescale 1ns/1ps
module lot_host (
  input wire logic clk_sys_i,
  input wire logic so_i,
  output logic cs_b_o,
  output logic sck_o,
  output logic si_o
);
  ////////////////////////////////////////////////////////////////////////
  // idle: deselected, clock low
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // select with clock already low, as mode 0 needs
  task automatic sel();
    @(negedge clk_sys_i) cs_b_o = 1'b0;
  endtask
  // n bits msb first; each clock level held two system clocks so the sampler sees it
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      @(negedge clk_sys_i) sck_o = 1'b0;
      si_o = tx[i];
      @(negedge clk_sys_i);
      @(negedge clk_sys_i) rx[i] = so_i;
      sck_o = 1'b1;
      @(negedge clk_sys_i);
    end
  endtask
  // opcode then na address bytes, msb first
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na);
    logic [7:0] r;
    xfer(op, 8, r);
    for (int i = 0; i < na; i++) begin
      xfer(a[23-8*i -: 8], 8, r);
    end
  endtask
  // release; data line no longer holds its last value, gap of two clocks
  task automatic desel();
    @(negedge clk_sys_i) sck_o = 1'b0;
    @(negedge clk_sys_i) cs_b_o = 1'b1;
    si_o = ~si_o;
    repeat (2) @(negedge clk_sys_i);
  endtask
endmodule

// >>> flash_lockdown_otp_access_tb_top.sv
// testbench for the lockdown query and security area program and read logic
`timescale 1ns/1ps
module flash_lockdown_otp_access_tb_top;
  logic clk_sys_i, rst_b_i, cs_b, sck, si, so, so_oe, write_enable_latch, susp, busy, wel_clr, susp_rej;
  logic [31:0] lockdown;
  logic [5:0] status_hi;
  logic [7:0] rx, st, e;
  logic [23:0] a;
  int errors, checked, seed, wcnt, done, k;
  int mem[128];
  ////////////////////////////////////////////////////////////////////////
  // short program time so busy spans a dozen status bytes
  lot_flash_lockdown_otp #(.NUM_SECTORS(32), .PROG_CYCLES(400)) u_dut (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .lockdown_i(lockdown), .write_enable_latch_i(write_enable_latch), .status_hi_i(status_hi),
    .suspend_req_i(susp), .ready_busy_flag_o(busy), .wel_clear_o(wel_clr), .suspend_rej_o(susp_rej));
  lot_host h (.clk_sys_i(clk_sys_i), .so_i(so), .cs_b_o(cs_b), .sck_o(sck), .si_o(si));
  ////////////////////////////////////////////////////////////////////////
  // clock and latch clear pulse counter
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (wel_clr === 1'b1) wcnt++;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // reset also models a fresh part: user bytes erased, factory half fixed
  task automatic do_reset();
    @(negedge clk_sys_i) rst_b_i = 1'b0;
    for (int i = 0; i < 128; i++) mem[i] = (i < 64) ? 8'hff : (8'h5a ^ i[5:0]);
    done = 0;
    repeat (3) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reference program: buffer wraps mod 64, applied only if the attempt is valid
  task automatic prog(input int ad, input int na, input int n, input int bits);
    int w0, ok, d;
    int bf[64];
    w0 = wcnt;
    ok = (write_enable_latch && !done && na == 3 && n > 0 && bits == 0);
    for (int j = 0; j < 64; j++) bf[j] = -1;
    h.sel();
    h.cmd(lot_pkg::OP_OTP_PROG, 24'(ad), na);
    for (int i = 0; i < n; i++) begin
      d = $random(seed) & 255;
      h.xfer(8'(d), 8, rx);
      bf[(ad + i) % 64] = d;
    end
    if (bits > 0) h.xfer(8'ha5, bits, rx);
    h.desel();
    for (int j = 0; j < 64; j++) if (ok && bf[j] >= 0) mem[j] = bf[j];
    if (ok) done = 1;
    cmp({7'h0, busy}, 8'(ok));
    cmp(8'(wcnt - w0), {7'h0, write_enable_latch});
  endtask
  // suspend refused while busy, then poll status until ready
  task automatic poll();
    @(negedge clk_sys_i) susp = 1'b1;
    @(negedge clk_sys_i);
    cmp({7'h0, susp_rej}, 8'h01);
    susp = 1'b0;
    @(negedge clk_sys_i);
    cmp({7'h0, susp_rej}, 8'h00);
    h.sel();
    h.cmd(lot_pkg::OP_STAT_RD, 24'h0, 0);
    k = 0;
    do begin
      h.xfer(8'($random(seed)), 8, st);
      k++;
    end while (st[0] === 1'b1 && k < 60);
    h.desel();
    cmp(8'(k > 1), 8'h01);
    cmp(st, {status_hi, write_enable_latch, 1'b0});
  endtask
  task automatic rd_otp(input int ad, input int n);
    h.sel();
    h.cmd(lot_pkg::OP_OTP_RD, 24'(ad), 3);
    h.xfer(8'($random(seed)), 8, rx);
    h.xfer(8'($random(seed)), 8, rx);
    for (int i = 0; i < n; i++) begin
      h.xfer(8'($random(seed)), 8, rx);
      cmp(rx, 8'(mem[(ad + i) % 128]));
    end
    h.xfer(8'h00, 5, rx);
    h.desel();
    cmp({7'h0, so_oe}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h1ebd;
    {rst_b_i, write_enable_latch, susp, wcnt, errors, checked} = '0;
    status_hi = 6'($random(seed));
    lockdown = $random(seed);
    do_reset();
    for (int s = 0; s < 6; s++) begin
      lockdown = $random(seed);
      a = 24'($random(seed));
      e = lockdown[a[20:16]] ? 8'hff : 8'h00;
      h.sel();
      h.cmd(lot_pkg::OP_LOCK_RD, a, 3);
      h.xfer(8'($random(seed)), 8, rx);
      h.xfer(8'($random(seed)), 8, rx);
      cmp(rx, e);
      h.xfer(8'($random(seed)), 3, rx);
      h.desel();
      cmp({7'h0, so_oe}, 8'h00);
    end
    prog(62, 3, 3, 0);
    write_enable_latch = 1'b1;
    prog(62, 2, 0, 0);
    prog(62, 3, 0, 0);
    prog(62, 3, 1, 3);
    prog(62, 3, 3, 0);
    poll();
    rd_otp(126, 70);
    prog(0, 3, 2, 0);
    do_reset();
    prog(16'h7f7e, 3, 66, 0);
    poll();
    rd_otp(0, 64);
    stop_test();
  end
  // watchdog well beyond the expected run of about half a millisecond
  initial begin
    #4000000;
    errors++;
    stop_test();
  end
endmodule
